// [dv/excitation_current_sva.sv]
// Assertions for the excitation current control block
`timescale 1ns/10ps
`include "excitation_current_defs.vh"
module excitation_current_sva (
	// Bus and analog controls
	input wire clk, rst, hsel, hwrite, hready,
	input wire [31:0] haddr, hwdata, hrdata,
	input wire [1:0] htrans,
	input wire block_power_down, current_reference_select,
	input wire excitation_source_0_enable, excitation_source_1_enable,
	input wire [3:0] excitation_source_0_pin_onehot,
	input wire [3:0] excitation_source_1_pin_onehot,
	input wire [10:0] source_current_ua
);
	// ----
	// Data phase flags; outputs land two edges after them
	// ----
	reg wc_q, wm_q, rd_q;
	reg [7:0] w_q;
	wire go = hsel & hready & htrans[1] & !rst;
	always @(posedge clk) begin
		wc_q <= go & hwrite & (haddr == `ADDR_SOURCE_CONTROL);
		wm_q <= go & hwrite & (haddr == `ADDR_CURRENT_MAGNITUDE);
		rd_q <= go & !hwrite;
		// Capture only in the data phase, when the written word stands
		if (wc_q | wm_q) begin
			w_q <= hwdata[7:0];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Register lands at the data phase edge, outputs one edge later
	pd_follow_a: assert property (
		wc_q |-> ##2 block_power_down == w_q[7])
		else $error("power down");
	ref_follow_a: assert property (
		wc_q |-> ##2 current_reference_select == w_q[6])
		else $error("reference select");
	src1_gate_a: assert property (
		wc_q |-> ##2 excitation_source_1_enable ==
		(w_q[5] & !w_q[7]))
		else $error("source 1 enable");
	src0_gate_a: assert property (
		wc_q |-> ##2 excitation_source_0_enable ==
		(w_q[2] & !w_q[7]))
		else $error("source 0 enable");
	src1_route_a: assert property (
		wc_q |-> ##2 excitation_source_1_pin_onehot ==
		(w_q[5] ? 4'h1 << w_q[4:3] : 4'h0))
		else $error("source 1 pin");
	src0_route_a: assert property (
		wc_q |-> ##2 excitation_source_0_pin_onehot ==
		(w_q[2] ? 4'h1 << w_q[1:0] : 4'h0))
		else $error("source 0 pin");
	current_code_a: assert property (
		wm_q |-> ##2 source_current_ua == 11'(50 * (w_q[2:1] + 1)
		* (w_q[5:3] > 5 ? 5 : w_q[5:3]) + 10 * w_q[0]))
		else $error("current value");
	read_zero_a: assert property (rd_q |-> hrdata[31:8] == 24'h0)
		else $error("reserved read bits");
	cover property (wc_q ##2 excitation_source_1_enable);
	cover property (wm_q ##2 source_current_ua == 11'h3f2);
	cover property (rd_q);
endmodule // excitation_current_sva
bind excitation_current_control excitation_current_sva sva_i (.*);

// [dv/test_excitation_current_control.sv]
// Self-checking bench for the excitation current control block
`timescale 1ns/10ps
`include "excitation_current_defs.vh"
module test_excitation_current_control;
	// ----
	// Stimulus, model state and design
	// ----
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0] htrans = 0;
	logic hready, hresp, pd, rs, e0, e1;
	logic [3:0] o0, o1;
	logic [10:0] ua;
	logic [22:0] x;
	logic [7:0] c = 8'hc0, m = 8'h06, d;
	int n_mismatch = 0, total_checks = 0, cyc = 0;
	always #50 clk = ~clk;
	excitation_current_control dut (.clk, .rst, .clk_en(1'b1), .hsel,
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
		.hreadyout(hready), .hresp, .block_power_down(pd),
		.current_reference_select(rs), .excitation_source_0_enable(e0),
		.excitation_source_0_pin_onehot(o0), .excitation_source_1_enable(e1),
		.excitation_source_1_pin_onehot(o1), .source_current_ua(ua));
	task chk(string s, logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	// Idle edge before each address phase keeps read-after-write safe
	task bus(logic w, logic [31:0] a, dw);
		@(posedge clk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= dw;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task check_all;
		bus(0, `ADDR_SOURCE_CONTROL, 0);
		chk("control", c, r);
		bus(0, `ADDR_CURRENT_MAGNITUDE, 0);
		chk("magnitude", m, r);
		x = {c[7], c[6], c[2] & ~c[7], c[2] ? 4'h1 << c[1:0] : 4'h0,
			c[5] & ~c[7], c[5] ? 4'h1 << c[4:3] : 4'h0,
			11'(50 * (m[2:1] + 1) * (m[5:3] > 5 ? 5 : m[5:3]) + 10 * m[0])};
		chk("pins", x[22:11], {pd, rs, e0, o0, e1, o1});
		chk("routing", x[20:11], {e0, o0, e1, o1});
		chk("current", x[10:0], ua);
	endtask
	task tally_and_finish;
		if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	initial begin
		void'($urandom(32'h74b53669));
		repeat (8) @(posedge clk);
		rst <= 0;
		check_all;
		for (int i = 0; i < 256; i++) begin
			d = i;
			bus(1, `ADDR_SOURCE_CONTROL, {$urandom, d});
			bus(1, `ADDR_CURRENT_MAGNITUDE, {$urandom, d});
			c = d;
			m = d & 8'h3f;
			if (i % 37 == 0) bus(1, `ADDR_CURRENT_MAGNITUDE + 4, $urandom);
			check_all;
		end
		bus(0, `ADDR_CURRENT_MAGNITUDE + 4, 0);
		chk("unmapped", 0, r);
		tally_and_finish;
	end
endmodule // test_excitation_current_control

// [rtl/excitation_current_control.v]
// Excitation current source control block with AHB-Lite register slave
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/10ps
`include "excitation_current_defs.vh"

module excitation_current_control (
	// Clock, reset, enable
	input wire clk,
	input wire rst,
	input wire clk_en,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	// Analog control outputs
	output reg block_power_down,
	output reg current_reference_select,
	output reg excitation_source_0_enable,
	output reg [3:0] excitation_source_0_pin_onehot,
	output reg excitation_source_1_enable,
	output reg [3:0] excitation_source_1_pin_onehot,
	output reg [10:0] source_current_ua
);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	reg [7:0] excitation_source_control_q;
	reg [5:0] excitation_current_magnitude_q;
	reg wr_pend_q;
	reg [31:0] wr_addr_q;

	wire [2:0] source1_pin_select;
	wire [2:0] source0_pin_select;
	wire [4:0] current_magnitude_code;
	wire extra_ten_microamp_enable;
	wire take;
	reg [2:0] units;
	reg [10:0] step_ua;
	reg [10:0] current_d;
	reg [3:0] sel0_d;
	reg [3:0] sel1_d;
	reg [31:0] rdata_d;

	assign source1_pin_select =
		excitation_source_control_q[`CTL_SRC1_EN_BIT:`CTL_SRC1_LSB];
	assign source0_pin_select =
		excitation_source_control_q[`CTL_SRC0_EN_BIT:`CTL_SRC0_LSB];
	assign current_magnitude_code = excitation_current_magnitude_q[5:1];
	assign extra_ten_microamp_enable =
		excitation_current_magnitude_q[`MAG_EXTRA_BIT];
	assign take = hsel & hready & htrans[1];

	// ----------------------------------------
	// Current decode
	// ----------------------------------------
	always @* begin
		// Codes above 101 clamp, so the product tops out at 1000 uA, or 1010 uA with the extra 10 uA
		units = excitation_current_magnitude_q[`MAG_UNITS_MSB:`MAG_UNITS_LSB];
		if (units > `MAG_UNITS_MAX) begin
			units = `MAG_UNITS_MAX;
		end
		case (excitation_current_magnitude_q[`MAG_STEP_MSB:`MAG_STEP_LSB])
			2'h3: step_ua = `STEP_CODE_11_UA;
			2'h2: step_ua = `STEP_CODE_10_UA;
			2'h1: step_ua = `STEP_CODE_01_UA;
			default: step_ua = `STEP_CODE_00_UA;
		endcase
		current_d = step_ua * {8'h00, units};
		if (extra_ten_microamp_enable) begin
			current_d = current_d + `EXTRA_CURRENT_UA;
		end
		// Reserved codes 000-011 leave the pin unrouted
		sel0_d = 4'h0;
		sel1_d = 4'h0;
		if (source0_pin_select[2]) begin
			sel0_d[source0_pin_select[1:0]] = 1'b1;
		end
		if (source1_pin_select[2]) begin
			sel1_d[source1_pin_select[1:0]] = 1'b1;
		end
	end

	// ----------------------------------------
	// Read data mux
	// ----------------------------------------
	always @* begin
		rdata_d = 32'h00000000;
		if (haddr == `ADDR_SOURCE_CONTROL) begin
			rdata_d = {24'h000000, excitation_source_control_q};
		end else if (haddr == `ADDR_CURRENT_MAGNITUDE) begin
			rdata_d = {26'h0000000, excitation_current_magnitude_q};
		end
	end

	// ----------------------------------------
	// Bus slave and registers
	// ----------------------------------------
	// Zero wait states; unmapped addresses read zero and drop writes
	always @(posedge clk) begin
		if (rst) begin
			excitation_source_control_q <= `RST_SOURCE_CONTROL;
			excitation_current_magnitude_q <= `RST_CURRENT_MAGNITUDE;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h00000000;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else if (clk_en) begin
			wr_pend_q <= take & hwrite;
			if (take) begin
				wr_addr_q <= haddr;
			end
			if (take & ~hwrite) begin
				hrdata <= rdata_d;
			end
			if (wr_pend_q) begin
				if (wr_addr_q == `ADDR_SOURCE_CONTROL) begin
					excitation_source_control_q <= hwdata[7:0];
				end else if (wr_addr_q == `ADDR_CURRENT_MAGNITUDE) begin
					// Bits 7:6 are not stored, so they read zero
					excitation_current_magnitude_q <= hwdata[5:0];
				end
			end
		end
	end

	// ----------------------------------------
	// Registered analog controls
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			block_power_down <= 1'b1;
			current_reference_select <= 1'b1;
			excitation_source_0_enable <= 1'b0;
			excitation_source_1_enable <= 1'b0;
			excitation_source_0_pin_onehot <= 4'h0;
			excitation_source_1_pin_onehot <= 4'h0;
			source_current_ua <= 11'h000;
		end else if (clk_en) begin
			block_power_down <=
				excitation_source_control_q[`CTL_POWER_DOWN_BIT];
			current_reference_select <=
				excitation_source_control_q[`CTL_REF_SELECT_BIT];
			// Power-down overrides both source enables, not the pin routing
			excitation_source_0_enable <= source0_pin_select[2] &
				~excitation_source_control_q[`CTL_POWER_DOWN_BIT];
			excitation_source_1_enable <= source1_pin_select[2] &
				~excitation_source_control_q[`CTL_POWER_DOWN_BIT];
			excitation_source_0_pin_onehot <= sel0_d;
			excitation_source_1_pin_onehot <= sel1_d;
			source_current_ua <= current_d;
		end
	end

endmodule // excitation_current_control

// [rtl/excitation_current_defs.vh]
// Offsets, field positions, reset values and decode constants
`ifndef EXCITATION_CURRENT_DEFS_VH
`define EXCITATION_CURRENT_DEFS_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_SOURCE_CONTROL 32'h40008850
`define ADDR_CURRENT_MAGNITUDE 32'h40008854

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SOURCE_CONTROL 8'hc0
`define RST_CURRENT_MAGNITUDE 6'h06

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CTL_POWER_DOWN_BIT 7
`define CTL_REF_SELECT_BIT 6
`define CTL_SRC1_EN_BIT 5
`define CTL_SRC1_LSB 3
`define CTL_SRC0_EN_BIT 2
`define CTL_SRC0_LSB 0

// ----------------------------------------
// Magnitude field positions and current values in microamps
// ----------------------------------------
`define MAG_UNITS_MSB 5
`define MAG_UNITS_LSB 3
`define MAG_STEP_MSB 2
`define MAG_STEP_LSB 1
`define MAG_EXTRA_BIT 0
`define MAG_UNITS_MAX 3'h5
`define STEP_CODE_11_UA 11'h0c8
`define STEP_CODE_10_UA 11'h096
`define STEP_CODE_01_UA 11'h064
`define STEP_CODE_00_UA 11'h032
`define EXTRA_CURRENT_UA 11'h00a

`endif
